// ---- hw/quadrature_encoder_interface.sv ----
// Quadrature encoder interface: phase/index decoding, 16-bit position counter, timer mode.
// Assumes encoder pins already synchronous to aclk and an AXI4-Lite master on the register side.
//
// What this block does
// - Phase A leading B counts up; A lagging B counts down.
// - Index modes: count reaching 0xFFFF or max plus one sets count error and interrupt.
// - Count error interrupt disable bit suppresses the count error interrupt.
// - After a count error counting continues; natural wrap raises no interrupt.
// - Count error flag is read/write and stays set until software clears it.
// - Index modes clear counter on qualified index only if index reset enable is set.
// - x4: index qualifies when phase B and A equal the two index match bits.
// - x2: upper match bit picks phase, lower bit gives its required level.
// - Index reset operation interrupts on index detection, not counter wrap.
// - Decoded direction drives an output pin and a control bit that is read-only in encoder modes.
// - Modes 100/101 count both edges of phase A only; B sets direction.
// - Modes 110/111 count every edge of both phases.
// - Modes 100/110 reset on qualified index; 101/111 reset on maximum count match.
// - Filter output changes only after three stable filter clock samples.
// - Filter clock is the system clock divided by two to the power of a three-bit field.
// - Filtered inputs used only when filter enable is set; disabled after reset.
// - Timer mode: count is timer, maximum is period; match sets interrupt flag.
// - Timer mode clocks from synchronised phase A; no asynchronous counting.
// - Switching encoder and timer modes keeps the count register unchanged.
// - Timer direction comes from phase B pin or written direction bit.
// - Sleep halts all counting in both modes.
// - Idle halts the block only when stop-in-idle is set; it resets to zero.
// - One shared interrupt flag collects all events; software clears it.
`timescale 1ns/100ps
module quadrature_encoder_interface #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address
  input  wire logic [qenc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read
  input  wire logic [qenc_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Encoder pins
  input  wire qenc_pkg::enc_pins_t        enc_pins,
  // CPU power state
  input  wire logic                       cpu_sleep,
  input  wire logic                       cpu_idle,
  // Status outputs
  output logic                            count_direction,
  output logic                            encoder_irq_flag
);
  import qenc_pkg::*;

  // Elaboration check: counter must be 2 to 16 bits wide
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must be between 2 and 16");
  end

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // Address decode shared by read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == OFS_CTRL) || (addr == OFS_FILT) || (addr == OFS_POS) ||
           (addr == OFS_MAX)  || (addr == OFS_STAT);
  endfunction : is_mapped

  // State
  enc_ctrl_t                 ctrl_reg;
  filt_ctrl_t                filt_reg;
  logic                      err_reg;
  logic                      err_next;
  logic                      dir_reg;
  logic                      dir_next;
  logic [CNT_W-1:0]          pos_reg;
  logic [CNT_W-1:0]          pos_next;
  logic [CNT_W-1:0]          max_reg;
  logic                      irq_reg;
  logic                      irq_next;
  logic [DIV_W-1:0]          div_cnt_reg;
  enc_pins_t                 prev_reg;
  enc_pins_t                 filt_out_reg;

  // Bus slave state
  logic                      aw_held_reg;
  logic [ADDR_W-1:0]         aw_addr_reg;
  logic                      w_held_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  logic                      bvalid_reg;
  logic [1:0]                bresp_reg;
  logic                      rvalid_reg;
  logic [31:0]               rdata_reg;
  logic [1:0]                rresp_reg;

  // Handshake outputs; one outstanding write and one read at a time
  assign awready = !aw_held_reg;
  assign wready  = !w_held_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  // Write fires once address and data are both held and the last response is gone
  wire wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_ctrl  = wr_fire && (aw_addr_reg == OFS_CTRL);
  wire wr_filt  = wr_fire && (aw_addr_reg == OFS_FILT);
  wire wr_pos   = wr_fire && (aw_addr_reg == OFS_POS);
  wire wr_max   = wr_fire && (aw_addr_reg == OFS_MAX);
  wire wr_stat  = wr_fire && (aw_addr_reg == OFS_STAT);

  // Read views of each register
  wire [31:0] ctrl_view = (32'h0000_0001 << CTRL_ERR_BIT) & {32{err_reg}}
                        | (32'h0000_0001 << CTRL_IDLE_BIT) & {32{ctrl_reg.stop_in_idle}}
                        | (32'h0000_0001 << CTRL_DIR_BIT) & {32{dir_reg}}
                        | {29'h0, ctrl_reg.encoder_mode_sel} << CTRL_MODE_LSB
                        | (32'h0000_0001 << CTRL_INDEX_RESET_ENABLE_BIT) & {32{ctrl_reg.index_reset_enable}}
                        | (32'h0000_0001 << CTRL_SRC_BIT) & {32{ctrl_reg.direction_source_sel}};
  wire [31:0] filt_view = {29'h0, filt_reg.filter_clock_divide} << FILT_DIV_LSB
                        | (32'h0000_0001 << FILT_OUT_BIT) & {32{filt_reg.filter_output_enable}}
                        | (32'h0000_0001 << FILT_COUNT_ERROR_IRQ_DISABLE_BIT) & {32{filt_reg.count_error_irq_disable}}
                        | {30'h0, filt_reg.index_match_value} << FILT_IMV_LSB;
  wire [31:0] pos_view  = {{(32-CNT_W){1'b0}}, pos_reg};
  wire [31:0] max_view  = {{(32-CNT_W){1'b0}}, max_reg};
  wire [31:0] stat_view = (32'h0000_0001 << STAT_IRQ_BIT) & {32{irq_reg}};

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_mux = (araddr == OFS_CTRL) ? ctrl_view :
                       (araddr == OFS_FILT) ? filt_view :
                       (araddr == OFS_POS)  ? pos_view  :
                       (araddr == OFS_MAX)  ? max_view  :
                       (araddr == OFS_STAT) ? stat_view : 32'h0000_0000;

  // Merged write values
  wire [31:0] ctrl_wval = merge_strb(ctrl_view, w_data_reg, w_strb_reg);
  wire [31:0] filt_wval = merge_strb(filt_view, w_data_reg, w_strb_reg);
  wire [31:0] pos_wval  = merge_strb(pos_view,  w_data_reg, w_strb_reg);
  wire [31:0] max_wval  = merge_strb(max_view,  w_data_reg, w_strb_reg);
  wire [31:0] stat_wval = w_data_reg & {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                                        {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Halt: sleep always stops the block, idle only when asked to
  wire halt = cpu_sleep || (cpu_idle && ctrl_reg.stop_in_idle);

  // Filter clock enable: divide by 2**filter_clock_divide, frozen while halted
  wire [DIV_W-1:0] div_limit = DIV_W'((8'h01 << filt_reg.filter_clock_divide) - 8'h01);
  wire             filt_tick = !halt && (div_cnt_reg >= div_limit);  // No stall when the field is lowered

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= '0;
    end else if (!halt) begin
      div_cnt_reg <= filt_tick ? '0 : DIV_W'(div_cnt_reg + 1'b1);
    end
  end

  // Three-sample noise filter per pin; output moves only on an unbroken run
  for (genvar ch = 0; ch < 3; ch++) begin : g_filter
    logic [FILT_DEPTH-1:0] hist_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hist_reg         <= '0;
        filt_out_reg[ch] <= 1'b0;
      end else if (filt_tick) begin
        hist_reg <= {hist_reg[FILT_DEPTH-2:0], enc_pins[ch]};
        if (&hist_reg) begin
          filt_out_reg[ch] <= 1'b1;
        end else if (~|hist_reg) begin
          filt_out_reg[ch] <= 1'b0;
        end
      end
    end
  end

  // Pin selection: raw pins unless the filter output is enabled
  wire enc_pins_t sel = filt_reg.filter_output_enable ? filt_out_reg : enc_pins;

  // Transition detection against the previous sample
  wire a_chg       = sel.phase_a ^ prev_reg.phase_a;
  wire b_chg       = sel.phase_b ^ prev_reg.phase_b;
  wire valid_trans = !halt && (a_chg ^ b_chg);
  wire dir_dec     = a_chg ? (sel.phase_a ^ sel.phase_b) : ~(sel.phase_a ^ sel.phase_b);
  wire index_rise  = sel.index && !prev_reg.index;
  wire a_rise      = sel.phase_a && !prev_reg.phase_a;

  // Mode decode
  wire enc_mode    = ctrl_reg.encoder_mode_sel[2];
  wire is_x4       = ctrl_reg.encoder_mode_sel[1];
  wire index_mode  = enc_mode && !ctrl_reg.encoder_mode_sel[0];
  wire timer_mode  = (ctrl_reg.encoder_mode_sel == MODE_TIMER);

  // Count pulses: x2 on phase A edges only, x4 on edges of both
  wire enc_step    = enc_mode && valid_trans && (is_x4 || a_chg);
  wire timer_step  = timer_mode && !halt && a_rise;
  wire timer_dir   = ctrl_reg.direction_source_sel ? sel.phase_b : dir_reg;
  wire count_up    = timer_mode ? timer_dir : dir_dec;

  // Index qualification against the match value
  wire [1:0] imv   = filt_reg.index_match_value;
  wire match_x4    = (sel.phase_b == imv[1]) && (sel.phase_a == imv[0]);
  wire match_x2    = ((imv[1] ? sel.phase_b : sel.phase_a) == imv[0]);
  wire index_qual  = index_mode && !halt && index_rise && (is_x4 ? match_x4 : match_x2);

  // Counter arithmetic
  wire [CNT_W-1:0] pos_inc   = CNT_W'(pos_reg + 1'b1);
  wire [CNT_W-1:0] pos_dec   = CNT_W'(pos_reg - 1'b1);
  wire [CNT_W-1:0] max_plus1 = CNT_W'(max_reg + 1'b1);
  wire             at_max    = (pos_reg == max_reg);
  wire             at_zero   = (pos_reg == '0);

  // Next count and events; a software write to the count wins over hardware
  logic irq_evt;
  logic err_evt;
  always_comb begin
    pos_next = pos_reg;
    irq_evt  = 1'b0;
    err_evt  = 1'b0;
    if (index_qual && ctrl_reg.index_reset_enable) begin
      pos_next = '0;
    end else if (enc_step || timer_step) begin
      if (timer_mode || ctrl_reg.encoder_mode_sel[0]) begin
        // Period or maximum count match wraps the count
        if (count_up) begin
          pos_next = at_max ? '0 : pos_inc;
          irq_evt  = at_max;
        end else begin
          pos_next = at_zero ? max_reg : pos_dec;
          irq_evt  = at_zero;
        end
      end else begin
        // Index modes: natural wrap, checked for a count error
        pos_next = count_up ? pos_inc : pos_dec;
        err_evt  = count_up ? (pos_inc == max_plus1) : (pos_dec == '1);
      end
    end
    if (index_qual) begin
      irq_evt = 1'b1;
    end
    if (err_evt && !filt_reg.count_error_irq_disable) begin
      irq_evt = 1'b1;
    end
    if (wr_pos) begin
      pos_next = pos_wval[CNT_W-1:0];
    end
  end

  // Flags: a hardware set in the same cycle beats a software clear
  assign err_next = err_evt || (wr_ctrl ? ctrl_wval[CTRL_ERR_BIT] : err_reg);
  assign irq_next = irq_evt || (irq_reg && !(wr_stat && stat_wval[STAT_IRQ_BIT]));

  // Direction: decoded in encoder mode, pin or written bit in timer mode
  always_comb begin
    dir_next = dir_reg;
    if (timer_mode) begin
      if (ctrl_reg.direction_source_sel) begin
        dir_next = sel.phase_b;
      end else if (wr_ctrl) begin
        dir_next = ctrl_wval[CTRL_DIR_BIT];
      end
    end else if (enc_mode && valid_trans) begin
      dir_next = dir_dec;
    end
  end

  // Core state; mode changes never touch the count register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      filt_reg <= FILT_RESET;
      err_reg  <= 1'b0;
      dir_reg  <= 1'b0;
      pos_reg  <= '0;
      max_reg  <= '1;
      irq_reg  <= 1'b0;
      prev_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.stop_in_idle         <= ctrl_wval[CTRL_IDLE_BIT];
        ctrl_reg.encoder_mode_sel     <= enc_mode_t'(ctrl_wval[CTRL_MODE_LSB +: 3]);
        ctrl_reg.index_reset_enable   <= ctrl_wval[CTRL_INDEX_RESET_ENABLE_BIT];
        ctrl_reg.direction_source_sel <= ctrl_wval[CTRL_SRC_BIT];
      end
      if (wr_filt) begin
        filt_reg.index_match_value       <= filt_wval[FILT_IMV_LSB +: 2];
        filt_reg.count_error_irq_disable <= filt_wval[FILT_COUNT_ERROR_IRQ_DISABLE_BIT];
        filt_reg.filter_output_enable    <= filt_wval[FILT_OUT_BIT];
        filt_reg.filter_clock_divide     <= filt_wval[FILT_DIV_LSB +: 3];
      end
      if (wr_max) begin
        max_reg <= max_wval[CNT_W-1:0];
      end
      err_reg <= err_next;
      dir_reg <= dir_next;
      pos_reg <= pos_next;
      irq_reg <= irq_next;
      if (!halt) begin
        prev_reg <= sel;  // Frozen while halted, so a pin change made while halted is seen as an edge on wake
      end
    end
  end

  // Pin outputs straight from flip-flops
  assign count_direction  = dir_reg;
  assign encoder_irq_flag = irq_reg;

  // Protection fields are accepted and ignored
  wire unused_prot = ^{awprot, arprot};

endmodule : quadrature_encoder_interface

// ---- hw/qenc_pkg.sv ----
// Shared constants and types for the quadrature encoder interface.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package qenc_pkg;

  // Register bus geometry
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_CTRL    = 5'h00;  // encoder_control_reg
  localparam logic [4:0]  OFS_FILT    = 5'h04;  // filter_control_reg
  localparam logic [4:0]  OFS_POS     = 5'h08;  // position_count
  localparam logic [4:0]  OFS_MAX     = 5'h0C;  // maximum_count
  localparam logic [4:0]  OFS_STAT    = 5'h10;  // encoder_irq_flag
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // encoder_control_reg field positions
  localparam int CTRL_ERR_BIT    = 15;
  localparam int CTRL_IDLE_BIT   = 13;
  localparam int CTRL_DIR_BIT    = 11;
  localparam int CTRL_MODE_LSB   = 8;
  localparam int CTRL_INDEX_RESET_ENABLE_BIT = 2;
  localparam int CTRL_SRC_BIT    = 0;

  // filter_control_reg field positions
  localparam int FILT_IMV_LSB    = 9;
  localparam int FILT_COUNT_ERROR_IRQ_DISABLE_BIT   = 8;
  localparam int FILT_OUT_BIT    = 7;
  localparam int FILT_DIV_LSB    = 4;

  // Status register field position
  localparam int STAT_IRQ_BIT    = 0;

  // Noise filter depth and divider width
  localparam int FILT_DEPTH      = 3;
  localparam int DIV_W           = 7;

  // Operating modes; codes not listed leave the block idle
  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_TIMER    = 3'b001,
    MODE_X2_INDEX = 3'b100,
    MODE_X2_MAX   = 3'b101,
    MODE_X4_INDEX = 3'b110,
    MODE_X4_MAX   = 3'b111
  } enc_mode_t;

  // Encoder pin group
  typedef struct packed {
    logic index;
    logic phase_b;
    logic phase_a;
  } enc_pins_t;

  // Control fields held by encoder_control_reg
  typedef struct packed {
    logic      stop_in_idle;
    enc_mode_t encoder_mode_sel;
    logic      index_reset_enable;
    logic      direction_source_sel;
  } enc_ctrl_t;

  // Control fields held by filter_control_reg
  typedef struct packed {
    logic [1:0] index_match_value;
    logic       count_error_irq_disable;
    logic       filter_output_enable;
    logic [2:0] filter_clock_divide;
  } filt_ctrl_t;

  localparam enc_ctrl_t  CTRL_RESET = '{stop_in_idle: 1'b0, encoder_mode_sel: MODE_OFF,
                                        index_reset_enable: 1'b0, direction_source_sel: 1'b0};
  localparam filt_ctrl_t FILT_RESET = '{index_match_value: 2'h0, count_error_irq_disable: 1'b0,
                                        filter_output_enable: 1'b0, filter_clock_divide: 3'h0};

endpackage : qenc_pkg

// ---- tb/qenc_encoder_model.sv ----
// Behavioural encoder: two phases in quadrature plus an index pulse.
// Assumes bench commands change just after rising edges of aclk.
`timescale 1ns/100ps
module qenc_encoder_model (
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Commands: step, its direction, a double change, an index
  input  wire logic           step,
  input  wire logic           rev,
  input  wire logic           jump,
  input  wire logic           idx,
  // Encoder pins
  output qenc_pkg::enc_pins_t pins
);
  import qenc_pkg::*;
  logic [1:0] turn_reg;
  // Gray order b,a of 00 01 11 10 going forward, so A leads B
  assign pins.phase_a = turn_reg[1] ^ turn_reg[0];
  assign pins.phase_b = turn_reg[1];
  assign pins.index   = idx && (turn_reg == 2'h0);
  // A double change is a fault only the bench asks for
  always_ff @(posedge aclk) begin
    if (!aresetn) turn_reg <= 2'h0;
    else if (jump) turn_reg <= turn_reg + 2'h2;
    else if (step) turn_reg <= rev ? turn_reg - 2'h1 : turn_reg + 2'h1;
  end
endmodule : qenc_encoder_model

// ---- tb/quadrature_encoder_interface_properties.sv ----
// Port-level checks for the quadrature encoder interface.
// Bound into the top module; sees its ports only.
`timescale 1ns/100ps
module quadrature_encoder_interface_properties #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Power state and status
  input wire logic        cpu_sleep,
  input wire logic        encoder_irq_flag
);
  import qenc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Three sleeping samples cover any decode pipeline before the flag
  chk_sleep_quiet: assert property (cpu_sleep && $past(cpu_sleep) && $past(cpu_sleep, 2) |-> !$rose(encoder_irq_flag))
    else $error("irq flag rose in sleep");
  // Only a bus write may lower the shared flag
  chk_irq_sticky: assert property (encoder_irq_flag && wready && !wvalid |=> encoder_irq_flag)
    else $error("irq flag fell without a write");
  // Bus handshakes: refusal while held, fixed answer times, answers stand
  chk_aw_refused: assert property (awvalid && awready |=> !awready)
    else $error("second address taken");
  chk_w_refused: assert property (wvalid && wready |=> !wready)
    else $error("second data taken");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule : quadrature_encoder_interface_properties

bind quadrature_encoder_interface quadrature_encoder_interface_properties #(.CNT_W(CNT_W)) props (.*);

// ---- tb/quadrature_encoder_interface_bench.sv ----
// Self-checking bench for the quadrature encoder interface.
// Drives the register bus and an encoder model from one 100 MHz clock.
`timescale 1ns/100ps
module quadrature_encoder_interface_bench;
  import qenc_pkg::*;
  // Bus, pin and status signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val, p0;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, cpu_sleep = 1'b0, cpu_idle = 1'b0;
  logic        step = 1'b0, rev = 1'b0, jump = 1'b0, idx = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, count_direction, encoder_irq_flag;
  enc_pins_t   pins;
  int          errors = 0, total_checks = 0;
  always #5 aclk = ~aclk;
  quadrature_encoder_interface uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .enc_pins(pins), .cpu_sleep,
    .cpu_idle, .count_direction, .encoder_irq_flag);
  qenc_encoder_model enc (.aclk, .aresetn, .step, .rev, .jump, .idx, .pins);
  // Verdict; also the end of any wait that runs out
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Write: address and data together, each dropped when taken; bready late
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      i++;
    end while (!bvalid && i < 64);
    if (!bvalid) begin
      chk(32'h0, 32'h1);
      summarize();
    end
    bready <= 1'b1;
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      i++;
    end while (!rvalid && i < 64);
    if (!rvalid) begin
      chk(32'h0, 32'h1);
      summarize();
    end
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    rd(a, rd_val);
    chk(rd_val, exp);
  endtask : rdc
  // Encoder steps five cycles apart, so each settles before the next
  task automatic mv(input int n, input logic r);
    repeat (n) begin
      step <= 1'b1;
      rev <= r;
      @(posedge aclk);
      step <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask : mv
  task automatic poke(input logic j);
    if (j) jump <= 1'b1;
    else idx <= 1'b1;
    @(posedge aclk);
    jump <= 1'b0;
    idx <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : poke
  task automatic home();
    repeat (4) if (pins.phase_a || pins.phase_b) mv(1, 1'b0);
  endtask : home
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_FILT, 32'h0);
    rdc(OFS_POS, 32'h0);
    rdc(OFS_MAX, 32'h0000FFFF);
    rdc(OFS_STAT, 32'h0);
    rdc(5'h14, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(5'h14, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    // x4 counting both ways; a double change is ignored
    wr(OFS_CTRL, 32'h0604);
    mv(5, 1'b0);
    rdc(OFS_POS, 32'h5);
    chk(32'(count_direction), 32'h1);
    rdc(OFS_CTRL, 32'h0E04);
    poke(1'b1);
    rdc(OFS_POS, 32'h5);
    mv(3, 1'b1);
    rdc(OFS_POS, 32'h2);
    chk(32'(count_direction), 32'h0);
    // Index clears only on a phase match; x2 reads the match bits apart
    poke(1'b0);
    rdc(OFS_POS, 32'h0);
    chk(32'(encoder_irq_flag), 32'h1);
    wr(OFS_STAT, 32'h1);
    chk(32'(encoder_irq_flag), 32'h0);
    mv(4, 1'b0);
    wr(OFS_FILT, 32'h0600);
    poke(1'b0);
    rdc(OFS_POS, 32'h4);
    chk(32'(encoder_irq_flag), 32'h0);
    wr(OFS_CTRL, 32'h0404);
    wr(OFS_FILT, 32'h0400);
    poke(1'b0);
    rdc(OFS_POS, 32'h0);
    mv(8, 1'b0);
    rdc(OFS_POS, 32'h4);
    wr(OFS_CTRL, 32'h0400);
    wr(OFS_STAT, 32'h1);
    poke(1'b0);
    rdc(OFS_POS, 32'h4);
    chk(32'(encoder_irq_flag), 32'h1);
    // Count error below zero, with and without its interrupt
    wr(OFS_CTRL, 32'h0600);
    wr(OFS_POS, 32'h0);
    wr(OFS_STAT, 32'h1);
    mv(1, 1'b1);
    rdc(OFS_POS, 32'hFFFF);
    chk(32'(encoder_irq_flag), 32'h1);
    mv(1, 1'b1);
    rdc(OFS_POS, 32'hFFFE);
    rdc(OFS_CTRL, 32'h8600);
    wr(OFS_CTRL, 32'h0600);
    rdc(OFS_CTRL, 32'h0600);
    wr(OFS_FILT, 32'h0100);
    wr(OFS_POS, 32'h0);
    wr(OFS_STAT, 32'h1);
    mv(1, 1'b1);
    chk(32'(encoder_irq_flag), 32'h0);
    rdc(OFS_CTRL, 32'h8600);
    // Wrap at the maximum count in x2 and x4
    wr(OFS_MAX, 32'h3);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h0700 : 32'h0500);
      wr(OFS_POS, 32'h0);
      wr(OFS_STAT, 32'h1);
      mv(k ? 4 : 8, 1'b0);
      rdc(OFS_POS, 32'h0);
      chk(32'(encoder_irq_flag), 32'h1);
    end
    // Timer on phase A rises, direction written or taken from phase B
    wr(OFS_POS, 32'h2);
    wr(OFS_CTRL, 32'h0900);
    rdc(OFS_POS, 32'h2);
    wr(OFS_STAT, 32'h1);
    mv(8, 1'b0);
    rdc(OFS_POS, 32'h0);
    chk(32'(encoder_irq_flag), 32'h1);
    wr(OFS_CTRL, 32'h0100);
    mv(4, 1'b0);
    rdc(OFS_POS, 32'h3);
    wr(OFS_CTRL, 32'h0101);
    home();
    mv(2, 1'b0);
    chk(32'(count_direction), 32'h1);
    rd(OFS_POS, p0);
    wr(OFS_CTRL, 32'h0600);
    rdc(OFS_POS, p0);
    // Sleep halts; idle halts only with stop_in_idle set
    cpu_sleep <= 1'b1;
    mv(4, 1'b0);
    cpu_sleep <= 1'b0;
    rdc(OFS_POS, p0);
    wr(OFS_CTRL, 32'h2600);
    cpu_idle <= 1'b1;
    mv(4, 1'b0);
    cpu_idle <= 1'b0;
    rdc(OFS_POS, p0);
    wr(OFS_CTRL, 32'h0600);
    cpu_idle <= 1'b1;
    mv(4, 1'b0);
    cpu_idle <= 1'b0;
    rdc(OFS_POS, p0 + 32'h4);
    // Slow filter clock hides quick moves; the fastest passes them
    home();
    rd(OFS_POS, p0);
    wr(OFS_FILT, 32'h00F0);
    mv(4, 1'b0);
    rdc(OFS_POS, p0);
    wr(OFS_FILT, 32'h0080);
    mv(4, 1'b0);
    repeat (2) @(posedge aclk);          // Last filtered edge counts late
    rdc(OFS_POS, p0 + 32'h4);
    summarize();
  end
endmodule : quadrature_encoder_interface_bench
